// [hdl/alarm_stop_sequencer.sv]
// Alarm stop sequencer: stop sequence, protection levels, clear detection
`timescale 1ns/1ps
`default_nettype none
`include "alarm_stop_consts.svh"

module alarm_stop_sequencer #(
  parameter int unsigned SAMPLE0_CYC = `ASQ_SAMPLE0_NS / `ASQ_CLK_NS,  // 0.166 ms
  parameter int unsigned SAMPLE1_CYC = `ASQ_SAMPLE1_NS / `ASQ_CLK_NS,  // 0.333 ms
  parameter int unsigned SAMPLE2_CYC = `ASQ_SAMPLE2_NS / `ASQ_CLK_NS,  // 1 ms
  parameter int unsigned SAMPLE3_CYC = `ASQ_SAMPLE3_NS / `ASQ_CLK_NS,  // 1.666 ms
  parameter int unsigned CLR_HOLD_CYC = `ASQ_CLR_HOLD_NS / `ASQ_CLK_NS // 120 ms
) (
  input  wire logic        i_sys_clk,        // 250 MHz clock
  input  wire logic        i_rst_n,          // Async reset, active low
  input  wire logic        i_ce,             // Clock enable, freezes all state
  input  wire logic [7:0]  i_addr,           // Register byte address
  input  wire logic [31:0] i_wdata,          // Write data
  input  wire logic        i_wr,             // Write strobe
  input  wire logic        i_rd,             // Read strobe
  output logic      [31:0] o_rdata,          // Read data, cycle after strobe
  input  wire logic        i_reload,         // Power restart, loads latched settings
  input  wire logic        i_alarm,          // External alarm detected
  input  wire logic        i_alarm_estop,    // Alarm is of emergency stop class
  input  wire logic        i_motor_stopped,  // Motor has come to rest
  input  wire logic [9:0]  i_load_pct,       // Load, percent
  input  wire logic [14:0] i_speed_rpm,      // Speed magnitude, r/min
  input  wire logic [15:0] i_travel,         // Over-travel, 0.1 rotation
  input  wire logic        i_alarm_clear,    // Alarm clear contact, asynchronous
  output logic             o_dyn_brake,      // Dynamic brake engaged
  output logic             o_servo_free,     // Drive output off
  output logic             o_estop_active,   // Emergency stop deceleration
  output logic      [9:0]  o_torque_limit,   // Torque limit, percent
  output logic             o_overload,       // Overload detected
  output logic             o_overspeed,      // Overspeed error
  output logic             o_overrun,        // Over-travel error
  output logic             o_irq             // Level interrupt
);
  import alarm_stop_pkg::*;

  // --------------------------------------------------------------------
  // Settings
  // --------------------------------------------------------------------
  logic [2:0]  alarm_stop_sequence_select_reg;  // Stop sequence code
  logic [9:0]  torque_reg;                      // Emergency stop torque
  logic [9:0]  overload_reg;                    // Overload level
  logic [14:0] overspeed_reg;                   // Overspeed level
  logic [10:0] overrun_reg;                     // Over-travel limit
  logic [1:0]  input_sample_period_select_reg;  // Written sample period
  logic        alarm_clear_method_select_reg;   // Written clear method
  logic [1:0]  period_act_reg;                  // Sample period in force
  logic        method_act_reg;                  // Clear method in force
  logic [2:0]  seq_act_reg;                     // Code latched at alarm
  logic [4:0]  irq_stat_reg;                    // Sticky events
  logic [4:0]  irq_mask_reg;                    // Interrupt enables
  logic [4:0]  irq_event;                       // Events this cycle
  seq_state_type state_reg;                     // Sequencer state
  seq_state_type state_next;                    // Next state

  wire wr_en = i_ce && i_wr;  // Qualified write

  // Out-of-range sequence and level writes are dropped; period, method and mask keep the low bits
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_stop_sequence_select_reg <= `ASQ_RST_SEQ;
      torque_reg                     <= `ASQ_RST_TORQUE;
      overload_reg                   <= `ASQ_RST_OVERLOAD;
      overspeed_reg                  <= `ASQ_RST_OVERSPEED;
      overrun_reg                    <= `ASQ_RST_OVERRUN;
      input_sample_period_select_reg <= `ASQ_RST_PERIOD;
      alarm_clear_method_select_reg  <= `ASQ_RST_METHOD;
      irq_mask_reg                   <= `ASQ_RST_IRQ;
    end else if (wr_en) begin
      case (i_addr)
        `ASQ_OFF_SEQ:       alarm_stop_sequence_select_reg <= (i_wdata > 32'h7) ?
                              alarm_stop_sequence_select_reg : i_wdata[2:0];
        `ASQ_OFF_TORQUE:    if (i_wdata <= 32'(`ASQ_MAX_TORQUE))
                              torque_reg <= i_wdata[9:0];
        `ASQ_OFF_OVERLOAD:  if (i_wdata <= 32'(`ASQ_MAX_OVERLOAD))
                              overload_reg <= i_wdata[9:0];
        `ASQ_OFF_OVERSPEED: if (i_wdata <= 32'(`ASQ_MAX_OVERSPEED))
                              overspeed_reg <= i_wdata[14:0];
        `ASQ_OFF_OVERRUN:   if (i_wdata <= 32'(`ASQ_MAX_OVERRUN))
                              overrun_reg <= i_wdata[10:0];
        `ASQ_OFF_PERIOD:    input_sample_period_select_reg <= i_wdata[1:0];
        `ASQ_OFF_METHOD:    alarm_clear_method_select_reg <= i_wdata[0];
        `ASQ_OFF_IRQ_MASK:  irq_mask_reg <= i_wdata[4:0];
        default: ;  // Read-only, write-one-clear status or unmapped
      endcase
    end
  end

  // Period and method only change at a restart, never mid-operation
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_act_reg <= `ASQ_RST_PERIOD;
      method_act_reg <= `ASQ_RST_METHOD;
    end else if (i_ce && i_reload) begin
      period_act_reg <= input_sample_period_select_reg;
      method_act_reg <= alarm_clear_method_select_reg;
    end
  end

  // --------------------------------------------------------------------
  // Protection levels
  // --------------------------------------------------------------------
  logic [9:0] ol_eff;  // Effective overload level
  assign ol_eff = (overload_reg >= `ASQ_CAP_OVERLOAD) ? `ASQ_CAP_OVERLOAD :
                  overload_reg;
  // A level of zero disables that check
  wire ol_hit = (ol_eff != 10'h000) && (i_load_pct >= ol_eff);
  wire os_hit = (overspeed_reg != 15'h0000) && (i_speed_rpm > overspeed_reg);
  wire or_hit = (overrun_reg != 11'h000) && (i_travel > {5'h00, overrun_reg});
  wire alarm_any = i_alarm || ol_hit || os_hit || or_hit;  // Any alarm cause

  // Detection flags are registered so they are glitch free
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overload  <= 1'b0;
      o_overspeed <= 1'b0;
      o_overrun   <= 1'b0;
    end else if (i_ce) begin
      o_overload  <= ol_hit;
      o_overspeed <= os_hit;
      o_overrun   <= or_hit;
    end
  end

  // --------------------------------------------------------------------
  // Alarm clear input: synchroniser, sampler and hold timer
  // --------------------------------------------------------------------
  logic        clr_meta_reg;   // First sync stage
  logic        clr_sync_reg;   // Second sync stage
  logic        clr_samp_reg;   // Value at last sample tick
  logic [31:0] tick_cnt_reg;   // Sample period counter
  logic [31:0] hold_cnt_reg;   // Held-high counter
  logic        hold_done_reg;  // Hold already reported
  logic [31:0] period_cyc;     // Selected period length
  logic        tick;           // Sample instant
  logic        clear_seen;     // Valid clear recognised

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_meta_reg <= 1'b0;
      clr_sync_reg <= 1'b0;
    end else if (i_ce) begin
      clr_meta_reg <= i_alarm_clear;
      clr_sync_reg <= clr_meta_reg;
    end
  end

  // Period decode from the code in force
  always_comb begin
    case (period_act_reg)
      2'h0:    period_cyc = SAMPLE0_CYC;
      2'h1:    period_cyc = SAMPLE1_CYC;
      2'h2:    period_cyc = SAMPLE2_CYC;
      2'h3:    period_cyc = SAMPLE3_CYC;
      default: period_cyc = SAMPLE0_CYC;
    endcase
  end
  assign tick = (tick_cnt_reg >= period_cyc - 32'h1);

  // Free-running sample timer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 32'h0;
      clr_samp_reg <= 1'b0;
    end else if (i_ce) begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      if (tick) begin
        clr_samp_reg <= clr_sync_reg;
      end
    end
  end

  // Hold timer rejects short contact bounces in method 0
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_cnt_reg  <= 32'h0;
      hold_done_reg <= 1'b0;
    end else if (i_ce) begin
      if (!clr_sync_reg) begin
        hold_cnt_reg  <= 32'h0;
        hold_done_reg <= 1'b0;
      end else if (hold_cnt_reg < CLR_HOLD_CYC) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end else begin
        hold_done_reg <= 1'b1;
      end
    end
  end

  // One pulse per press in either method
  always_comb begin
    if (method_act_reg) begin
      clear_seen = tick && clr_sync_reg && !clr_samp_reg;
    end else begin
      clear_seen = clr_sync_reg && (hold_cnt_reg >= CLR_HOLD_CYC) && !hold_done_reg;
    end
  end

  // --------------------------------------------------------------------
  // Stop sequence state machine
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (alarm_any) begin
          state_next = (alarm_stop_sequence_select_reg[2] && i_alarm_estop) ?
                       ST_ESTOP : ST_DECEL;
        end
      end
      ST_ESTOP: if (i_motor_stopped) state_next = ST_HOLD;
      ST_DECEL: if (i_motor_stopped) state_next = ST_HOLD;
      ST_HOLD:  if (clear_seen) state_next = ST_RUN;
      default:  state_next = ST_RUN;
    endcase
  end

  // State and the code latched at the alarm
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= ST_RUN;
      seq_act_reg <= `ASQ_RST_SEQ;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_reg == ST_RUN) begin
        seq_act_reg <= alarm_stop_sequence_select_reg;  // Code fixed for the sequence
      end
    end
  end

  // Drive outputs follow the state one cycle later
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dyn_brake    <= 1'b0;
      o_servo_free   <= 1'b0;
      o_estop_active <= 1'b0;
      o_torque_limit <= `ASQ_RST_TORQUE;
    end else if (i_ce) begin
      o_estop_active <= (state_reg == ST_ESTOP);
      o_torque_limit <= (state_reg == ST_ESTOP) ? torque_reg : `ASQ_MAX_TORQUE;
      case (state_reg)
        ST_DECEL: begin
          o_dyn_brake  <= !seq_act_reg[0];
          o_servo_free <= seq_act_reg[0];
        end
        ST_HOLD: begin
          o_dyn_brake  <= !seq_act_reg[1];
          o_servo_free <= seq_act_reg[1];
        end
        default: begin
          o_dyn_brake  <= 1'b0;
          o_servo_free <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupts and read port
  // --------------------------------------------------------------------
  assign irq_event = {clear_seen, or_hit, os_hit, ol_hit,
                      (state_reg == ST_RUN) && alarm_any};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_reg <= `ASQ_RST_IRQ;
    end else if (i_ce) begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_en && i_addr == `ASQ_OFF_IRQ_STAT) ?
                      i_wdata[4:0] : 5'h00)) | irq_event;
    end
  end

  assign o_irq = |(irq_stat_reg & irq_mask_reg);  // Level interrupt

  // Read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (i_ce) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          `ASQ_OFF_SEQ:       o_rdata <= {29'h0, alarm_stop_sequence_select_reg};
          `ASQ_OFF_TORQUE:    o_rdata <= {22'h0, torque_reg};
          `ASQ_OFF_OVERLOAD:  o_rdata <= {22'h0, overload_reg};
          `ASQ_OFF_OVERSPEED: o_rdata <= {17'h0, overspeed_reg};
          `ASQ_OFF_OVERRUN:   o_rdata <= {21'h0, overrun_reg};
          `ASQ_OFF_PERIOD:    o_rdata <= {30'h0, input_sample_period_select_reg};
          `ASQ_OFF_METHOD:    o_rdata <= {31'h0, alarm_clear_method_select_reg};
          `ASQ_OFF_STATUS:    o_rdata <= {25'h0, o_overrun, o_overspeed, o_overload,
                                          state_reg};
          `ASQ_OFF_IRQ_STAT:  o_rdata <= {27'h0, irq_stat_reg};
          `ASQ_OFF_IRQ_MASK:  o_rdata <= {27'h0, irq_mask_reg};
          default:            o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence decel_seen_s;
    i_ce && state_reg == ST_DECEL;
  endsequence

  decel_brake_a: assert property (decel_seen_s ##0 !seq_act_reg[0] |=> o_dyn_brake && !o_servo_free)
    else $error("Brake deceleration not applied");
  decel_coast_a: assert property (decel_seen_s ##0 seq_act_reg[0] |=> o_servo_free && !o_dyn_brake)
    else $error("Free-run deceleration not applied");
  estop_entry_a: assert property (i_ce && state_reg == ST_RUN && alarm_any && i_alarm_estop && alarm_stop_sequence_select_reg[2] |=> state_reg == ST_ESTOP ##1 o_estop_active || !i_ce)
    else $error("Emergency stop not entered");
  plain_entry_a: assert property (i_ce && state_reg == ST_RUN && alarm_any && !(i_alarm_estop && alarm_stop_sequence_select_reg[2]) |=> state_reg == ST_DECEL)
    else $error("Plain deceleration not entered");
  stop_torque_a: assert property (i_ce && state_reg == ST_ESTOP |=> o_torque_limit == $past(torque_reg))
    else $error("Stop torque limit wrong");
  overload_cap_a: assert property (i_ce && overload_reg >= 10'h073 && i_load_pct >= 10'h073 |=> o_overload)
    else $error("Overload cap missed");
  overspeed_det_a: assert property (i_ce |=> o_overspeed == ($past(overspeed_reg) != 15'h0 && $past(i_speed_rpm) > $past(overspeed_reg)))
    else $error("Overspeed flag wrong");
  overrun_det_a: assert property (i_ce |=> o_overrun == ($past(overrun_reg) != 11'h0 && $past(i_travel) > {5'h0, $past(overrun_reg)}))
    else $error("Over-travel flag wrong");
  tick_restart_a: assert property (i_ce && tick |=> tick_cnt_reg == 32'h0)
    else $error("Sample timer did not restart");
  hold_clear_a: assert property (clear_seen && !method_act_reg |-> clr_sync_reg && hold_cnt_reg == CLR_HOLD_CYC)
    else $error("Clear accepted before hold time");
  sample_clear_a: assert property (clear_seen && method_act_reg |-> tick && !clr_samp_reg)
    else $error("Clear accepted off a sample tick");
  hold_wait_a: assert property (i_ce && state_reg == ST_HOLD && !clear_seen |=> state_reg == ST_HOLD)
    else $error("Post-stop state left without clear");
endmodule : alarm_stop_sequencer
`default_nettype wire

// [hdl/alarm_stop_consts.svh]
// Constants of the alarm stop sequencer: offsets, fields, resets, timing
//
// Notes on behaviour
// - Codes 0-3: brake or coast, then brake/free
// - Codes 4-7: emergency stop first on e-stop alarms
// - Emergency stop torque limit 0 to 500 percent
// - Overload level 0-500, capped at 115 percent
// - Overspeed error above level, 0 to 20000 rpm
// - Over-travel limit in tenth rotations, default 10
// - Input sample period from four codes, after restart
// - Method 0: clear input held 120 ms
// - Method 1: clear input taken at sample ticks
`ifndef ALARM_STOP_CONSTS_SVH
`define ALARM_STOP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASQ_OFF_SEQ       8'h00
`define ASQ_OFF_TORQUE    8'h04
`define ASQ_OFF_OVERLOAD  8'h08
`define ASQ_OFF_OVERSPEED 8'h0c
`define ASQ_OFF_OVERRUN   8'h10
`define ASQ_OFF_PERIOD    8'h14
`define ASQ_OFF_METHOD    8'h18
`define ASQ_OFF_STATUS    8'h1c
`define ASQ_OFF_IRQ_STAT  8'h20
`define ASQ_OFF_IRQ_MASK  8'h24

// ----------------------------------------------------------------------
// Reset values and setting limits
// ----------------------------------------------------------------------
`define ASQ_RST_SEQ       3'h0
`define ASQ_RST_TORQUE    10'h000
`define ASQ_RST_OVERLOAD  10'h000
`define ASQ_RST_OVERSPEED 15'h0000
`define ASQ_RST_OVERRUN   11'h00a
`define ASQ_RST_PERIOD    2'h0
`define ASQ_RST_METHOD    1'h0
`define ASQ_RST_IRQ       5'h00
`define ASQ_MAX_TORQUE    10'h1f4
`define ASQ_MAX_OVERLOAD  10'h1f4
`define ASQ_CAP_OVERLOAD  10'h073
`define ASQ_MAX_OVERSPEED 15'h4e20
`define ASQ_MAX_OVERRUN   11'h3e8

// ----------------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------------
`define ASQ_IRQ_ALARM     0
`define ASQ_IRQ_OVERLOAD  1
`define ASQ_IRQ_OVERSPEED 2
`define ASQ_IRQ_OVERRUN   3
`define ASQ_IRQ_CLEARED   4

// ----------------------------------------------------------------------
// Timing, in nanoseconds, at a 4 ns clock
// ----------------------------------------------------------------------
`define ASQ_CLK_NS        4
`define ASQ_SAMPLE0_NS    166000
`define ASQ_SAMPLE1_NS    333000
`define ASQ_SAMPLE2_NS    1000000
`define ASQ_SAMPLE3_NS    1666000
`define ASQ_CLR_HOLD_NS   120000000

`endif

// [hdl/alarm_stop_pkg.sv]
// Types shared by the alarm stop sequencer
package alarm_stop_pkg;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,  // Normal operation
    ST_ESTOP = 4'b0010,  // Emergency stop deceleration
    ST_DECEL = 4'b0100,  // Brake or coast deceleration
    ST_HOLD  = 4'b1000   // Stopped, waiting for alarm clear
  } seq_state_type;
endpackage : alarm_stop_pkg

// [verif/motor_model.sv]
// Servomotor model: runs down to rest a fixed time after losing drive
`timescale 1ns/1ps
`default_nettype none

module motor_model #(
  parameter int unsigned STOP_CYC = 10  // Run-down time in cycles
) (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_rst_n,    // Async reset, active low
  input  wire logic i_coast,    // Drive removed, motor slowing
  output logic      o_stopped   // Motor at rest
);
  int unsigned cnt_reg;  // Cycles since the drive was removed

  // Never at rest early: a live drive keeps the shaft turning
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 0;
    end else if (!i_coast) begin
      cnt_reg <= 0;
    end else if (cnt_reg < STOP_CYC) begin
      cnt_reg <= cnt_reg + 1;
    end
  end

  assign o_stopped = (cnt_reg == STOP_CYC);
endmodule : motor_model
`default_nettype wire

// [verif/alarm_stop_sequencer_bench.sv]
// Self-checking bench for the alarm stop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "alarm_stop_consts.svh"

module alarm_stop_sequencer_bench;
  import alarm_stop_pkg::*;
  localparam int CLR_CYC = 50;  // Shortened clear hold time
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, reload = 0;
  logic        alarm = 0, estop = 0, coast = 0, clr = 0, stopped;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wdata  = 32'h0, rdata, rv;
  logic [9:0]  load   = 10'h000, tlim;
  logic [14:0] speed  = 15'h0000;
  logic [15:0] travel = 16'h0000;
  logic        brake, free, est_on, ovl, ovs, ovr, irq;
  int          miscompares = 0, num_checks = 0;
  int          rst_v[11] = '{0, 0, 0, 0, 10, 0, 0, 1, 0, 0, 0};  // Reset table, 0x28 unmapped
  int          bad_v[5]  = '{8, 501, 501, 20001, 1001};         // Refused settings
  int          good_v[5] = '{7, 300, 200, 1000, 10};            // Accepted settings
  int          lo_v[3]   = '{114, 1000, 10};                    // Highest value that does not trip each check
  int          hi_v[3]   = '{115, 1001, 11};                    // Lowest value that trips each check
  int          per_v[4]  = '{8, 16, 32, 64};                    // Sample periods in cycles
  time         last_rel  = 0, t0 = 0;                           // Moments the drive let go

  initial forever #2 clk = ~clk;  // 250 MHz

  alarm_stop_sequencer #(.SAMPLE0_CYC(8), .SAMPLE1_CYC(16), .SAMPLE2_CYC(32),
    .SAMPLE3_CYC(64), .CLR_HOLD_CYC(CLR_CYC)) alarm_stop_sequencer_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_reload(reload), .i_alarm(alarm),
    .i_alarm_estop(estop), .i_motor_stopped(stopped), .i_load_pct(load),
    .i_speed_rpm(speed), .i_travel(travel), .i_alarm_clear(clr), .o_dyn_brake(brake),
    .o_servo_free(free), .o_estop_active(est_on), .o_torque_limit(tlim),
    .o_overload(ovl), .o_overspeed(ovs), .o_overrun(ovr), .o_irq(irq));

  motor_model motor_model_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_coast(coast),
    .o_stopped(stopped));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Lands just after an edge so the edge's updates have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wreg(input int a, input int d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a[7:0];
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input int a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a[7:0];
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rreg

  // Still stopped after lo cycles of clear, running again within hi more
  task automatic release_hold(input int lo, input int hi);
    int n = 0;
    @(posedge clk);
    alarm <= 1'b0;
    estop <= 1'b0;
    clr   <= 1'b1;
    cyc(lo);
    check(brake | free, 1'b1);
    while ((brake | free) && n < hi) begin
      cyc(1);
      n++;
    end
    last_rel = $time;  // Outputs dropped two cycles after the clear
    check(brake | free, 1'b0);
    @(posedge clk);
    clr   <= 1'b0;
    coast <= 1'b0;
  endtask : release_hold

  // Drives one protection input, the others idle
  task automatic hit(input int k, input int v, input logic [2:0] exp);
    @(posedge clk);
    load   <= (k == 0) ? v[9:0] : 10'h000;
    speed  <= (k == 1) ? v[14:0] : 15'h0000;
    travel <= (k == 2) ? v[15:0] : 16'h0000;
    cyc(2);
    check({ovr, ovs, ovl}, exp);
  endtask : hit

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Watchdog: the tests need well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rreg(i * 4);
      check(rv, rst_v[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wreg(i * 4, bad_v[i]);
      rreg(i * 4);
      check(rv, rst_v[i]);
      wreg(i * 4, good_v[i]);
      rreg(i * 4);
      check(rv, good_v[i]);
    end
    wreg(`ASQ_OFF_STATUS, 0);
    rreg(`ASQ_OFF_STATUS);
    check(rv, 1);
    wreg(`ASQ_OFF_METHOD, 1);  // Not in force until a restart
    rreg(`ASQ_OFF_METHOD);
    check(rv, 1);
    // Every stop code; odd ones see an emergency-stop-class alarm
    for (int c = 0; c < 8; c++) begin
      wreg(`ASQ_OFF_SEQ, c);
      @(posedge clk);
      alarm <= 1'b1;
      estop <= c[0];
      coast <= 1'b1;
      cyc(3);
      check(est_on, c[2] & c[0]);
      check(tlim, (c[2] & c[0]) ? 10'h12c : 10'h1f4);
      if (!(c[2] & c[0])) begin
        check(brake, !c[0]);
      end
      cyc(12);
      rreg(`ASQ_OFF_STATUS);
      check(rv[3:0], ST_HOLD);
      check({est_on, brake, free}, {1'b0, !c[1], c[1]});
      release_hold(CLR_CYC - 10, 30);
    end
    @(posedge clk);
    reload <= 1'b1;
    @(posedge clk);
    reload <= 1'b0;
    // Protection levels; each hit also stops the drive
    for (int k = 0; k < 3; k++) begin
      hit(k, lo_v[k], 3'h0);
      hit(k, hi_v[k], 3'h1 << k);
      @(posedge clk);
      coast <= 1'b1;
      hit(k, 0, 3'h0);
      cyc(14);
      release_hold(1, 25);
    end
    rreg(`ASQ_OFF_IRQ_STAT);
    check(rv, 32'h1f);
    check(irq, 1'b0);
    wreg(`ASQ_OFF_IRQ_MASK, 32'h2);
    cyc(1);
    check(irq, 1'b1);
    wreg(`ASQ_OFF_IRQ_STAT, 32'h1f);
    cyc(1);
    check(irq, 1'b0);
    rreg(`ASQ_OFF_IRQ_STAT);
    check(rv, 32'h0);
    // Slower sample periods: two clears in a row land whole periods apart
    for (int p = 1; p < 4; p++) begin
      wreg(`ASQ_OFF_PERIOD, p);
      @(posedge clk);
      reload <= 1'b1;
      @(posedge clk);
      reload <= 1'b0;
      for (int j = 0; j < 2; j++) begin
        cyc(per_v[p]);  // A tick must see the contact open first
        @(posedge clk);
        alarm <= 1'b1;
        coast <= 1'b1;
        cyc(14);
        t0 = last_rel;
        release_hold(1, per_v[p] + 4);
      end
      check(32'((last_rel - t0) / 4 % per_v[p]), 32'h0);
    end
    close_out();
  end
endmodule : alarm_stop_sequencer_bench
`default_nettype wire
